// File: asqc_pkg.sv
package asqc_pkg;

  // ****************************************************************
  // Word layout and sequence constants
  // ****************************************************************
  localparam int unsigned WORD_W        = 36;
  localparam int unsigned SHIFT_CNT_W   = 6;
  localparam int unsigned ROT_PLACES    = 36;
  localparam int unsigned TEST_BIT_LO   = 34;
  localparam int unsigned TEST_BIT_HI   = 35;
  // Shifting past this count would test bits that were already tested.
  localparam int unsigned SF_MAX_SHIFTS = WORD_W - 2;

  localparam logic [WORD_W-1:0]      WORD_RESET  = 36'h0_0000_0000;
  localparam logic [SHIFT_CNT_W-1:0] COUNT_RESET = 6'h00;
  localparam logic [SHIFT_CNT_W-1:0] ROT_LAST    = 6'(ROT_PLACES - 1);
  localparam logic [SHIFT_CNT_W-1:0] SF_LAST     = 6'(SF_MAX_SHIFTS);

  // ****************************************************************
  // Sequence states, one-hot
  // ****************************************************************
  typedef enum logic [16:0] {
    ST_IDLE    = 17'h00001,
    ST_L_XFER  = 17'h00002,
    ST_L_LOAD  = 17'h00004,
    ST_L_PROBE = 17'h00008,
    ST_L_SETB  = 17'h00010,
    ST_L_COMP1 = 17'h00020,
    ST_L_SETC  = 17'h00040,
    ST_L_QX    = 17'h00080,
    ST_L_SETD  = 17'h00100,
    ST_L_COMP2 = 17'h00200,
    ST_L_SETE  = 17'h00400,
    ST_L_XQ    = 17'h00800,
    ST_L_END   = 17'h01000,
    ST_S_ROT   = 17'h02000,
    ST_S_TEST  = 17'h04000,
    ST_D_CHECK = 17'h08000,
    ST_D_CLEAR = 17'h10000
  } asqc_state_t;

  // ****************************************************************
  // Flags and probe chain of the logical sequence
  // ****************************************************************
  typedef struct packed {
    logic extended_sequence_flag;
    logic logical_busy_flag;
    logic delayed_add_flag;
    logic right_probe_flag;
    logic left_probe_flag;
    logic restore_exchange_flag;
    logic b_probe;
    logic c_probe;
    logic d_probe;
    logic e_probe;
  } asqc_flags_t;

  // Pulses issued to the rest of the machine; each lasts one cycle, except div_probe, which stays high for two.
  typedef struct packed {
    logic resume;
    logic right_probe;
    logic left_probe;
    logic div_probe;
  } asqc_pulses_t;

  // Whole module state.
  typedef struct packed {
    asqc_state_t             st;
    logic [WORD_W-1:0]       q;
    logic [WORD_W-1:0]       x;
    logic [WORD_W-1:0]       a;
    logic [SHIFT_CNT_W-1:0]  shift_counter;
    logic [SHIFT_CNT_W-1:0]  cnt;
    asqc_flags_t             flags;
    logic [1:0]              div_chk;
    logic                    fault_stop;
    asqc_pulses_t            pulses;
  } asqc_regs_t;

endpackage

// File: asqc_arith_seq_ctrl.sv
module asqc_arith_seq_ctrl (
  input  wire logic                             core_clk,
  input  wire logic                             reset_n,
  input  wire logic                             start_logical,
  input  wire logic                             start_scale,
  input  wire logic                             start_divide,
  input  wire logic [1:0]                       div_check_cond,
  input  wire logic                             fault_clear,
  input  wire logic                             load_q,
  input  wire logic                             load_a,
  input  wire logic [asqc_pkg::WORD_W-1:0]      load_data,
  output logic      [asqc_pkg::WORD_W-1:0]      q_word,
  output logic      [asqc_pkg::WORD_W-1:0]      x_word,
  output logic      [asqc_pkg::WORD_W-1:0]      a_word,
  output logic      [asqc_pkg::SHIFT_CNT_W-1:0] shift_counter,
  output asqc_pkg::asqc_flags_t                 flags,
  output asqc_pkg::asqc_pulses_t                pulses,
  output logic      [1:0]                       div_check_ff,
  output logic                                  fault_a_stop,
  output logic                                  busy
);
  import asqc_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // One place of left circular shift; used by rotation and normalising.
  function automatic logic [WORD_W-1:0] rotl1(input logic [WORD_W-1:0] w);
    return {w[WORD_W-2:0], w[WORD_W-1]};
  endfunction

  asqc_regs_t s_r;
  asqc_regs_t s_nxt;
  logic       idle;
  logic       bits_differ;

  assign idle        = (s_r.st == ST_IDLE);
  assign bits_differ = s_r.a[TEST_BIT_LO] != s_r.a[TEST_BIT_HI];

  // ****************************************************************
  // Sequence engine
  // ****************************************************************

  // Next state. Commands arriving while busy are ignored, so steps never overlap.
  always_comb begin
    s_nxt        = s_r;
    s_nxt.pulses = '0;
    case (s_r.st)
      ST_IDLE: begin
        if (load_q) begin
          s_nxt.q = load_data;
        end
        if (load_a) begin
          s_nxt.a = load_data;
        end
        // Start commands are mutually exclusive; the first in this order wins.
        if (start_logical) begin
          s_nxt.st = ST_L_XFER;
        end else if (start_scale) begin
          s_nxt.st  = ST_S_ROT;
          s_nxt.cnt = COUNT_RESET;
        end else if (start_divide) begin
          s_nxt.st = ST_D_CHECK;
        end
      end
      ST_L_XFER: begin
        s_nxt.x                            = s_r.q;
        s_nxt.flags.extended_sequence_flag = 1'b1;
        s_nxt.flags.logical_busy_flag      = 1'b1;
        s_nxt.flags.delayed_add_flag       = 1'b1;
        s_nxt.st                           = ST_L_LOAD;
      end
      ST_L_LOAD: begin
        s_nxt.a                      = s_r.x;
        s_nxt.flags.delayed_add_flag = 1'b0;
        s_nxt.flags.right_probe_flag = 1'b1;
        s_nxt.flags.left_probe_flag  = 1'b1;
        s_nxt.st                     = ST_L_PROBE;
      end
      ST_L_PROBE: begin
        s_nxt.pulses.right_probe = s_r.flags.right_probe_flag;
        s_nxt.pulses.left_probe  = s_r.flags.left_probe_flag;
        s_nxt.x                  = WORD_RESET;
        s_nxt.st                 = ST_L_SETB;
      end
      ST_L_SETB: begin
        s_nxt.flags.right_probe_flag      = 1'b0;
        s_nxt.flags.left_probe_flag       = 1'b0;
        s_nxt.flags.restore_exchange_flag = 1'b1;
        s_nxt.flags.b_probe               = 1'b1;
        s_nxt.st                          = ST_L_COMP1;
      end
      ST_L_COMP1: begin
        s_nxt.x  = ~s_r.x;
        s_nxt.st = ST_L_SETC;
      end
      ST_L_SETC: begin
        s_nxt.flags.b_probe               = 1'b0;
        s_nxt.flags.restore_exchange_flag = 1'b0;
        s_nxt.flags.c_probe               = 1'b1;
        s_nxt.st                          = ST_L_QX;
      end
      ST_L_QX: begin
        s_nxt.x  = s_r.q;
        s_nxt.q  = WORD_RESET;
        s_nxt.st = ST_L_SETD;
      end
      ST_L_SETD: begin
        s_nxt.flags.c_probe                = 1'b0;
        s_nxt.flags.extended_sequence_flag = 1'b0;
        s_nxt.flags.d_probe                = 1'b1;
        s_nxt.st                           = ST_L_COMP2;
      end
      ST_L_COMP2: begin
        s_nxt.x  = ~s_r.x;
        s_nxt.st = ST_L_SETE;
      end
      ST_L_SETE: begin
        s_nxt.flags.d_probe = 1'b0;
        s_nxt.flags.e_probe = 1'b1;
        s_nxt.st            = ST_L_XQ;
      end
      ST_L_XQ: begin
        s_nxt.q             = s_r.x;
        s_nxt.x             = WORD_RESET;
        s_nxt.pulses.resume = 1'b1;
        s_nxt.st            = ST_L_END;
      end
      ST_L_END: begin
        s_nxt.flags.e_probe           = 1'b0;
        s_nxt.flags.logical_busy_flag = 1'b0;
        s_nxt.st                      = ST_IDLE;
      end
      ST_S_ROT: begin
        // A full turn leaves the word in place but costs one clock a place.
        s_nxt.a   = rotl1(s_r.a);
        s_nxt.cnt = s_r.cnt + 6'h01;
        if (s_r.cnt == ROT_LAST) begin
          s_nxt.st  = ST_S_TEST;
          s_nxt.cnt = COUNT_RESET;
        end
      end
      ST_S_TEST: begin
        if (bits_differ || (s_r.cnt == SF_LAST)) begin
          s_nxt.shift_counter = s_r.cnt;
          s_nxt.pulses.resume = 1'b1;
          s_nxt.st            = ST_IDLE;
        end else begin
          s_nxt.a   = rotl1(s_r.a);
          s_nxt.cnt = s_r.cnt + 6'h01;
        end
      end
      ST_D_CHECK: begin
        // Checks are taken here, before the divide would shift anything.
        s_nxt.div_chk          = div_check_cond;
        s_nxt.pulses.div_probe = 1'b1;
        s_nxt.st               = ST_D_CLEAR;
      end
      ST_D_CLEAR: begin
        s_nxt.div_chk          = 2'h0;
        s_nxt.pulses.div_probe = 1'b1;
        s_nxt.pulses.resume    = 1'b1;
        s_nxt.st               = ST_IDLE;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // Fault stop: a new divide-check stop wins over a clear in the same cycle.
    if (fault_clear) begin
      s_nxt.fault_stop = 1'b0;
    end
    if ((s_r.st == ST_D_CHECK) && (|div_check_cond)) begin
      s_nxt.fault_stop = 1'b1;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_r               <= '0;
      s_r.st            <= ST_IDLE;
      s_r.q             <= WORD_RESET;
      s_r.x             <= WORD_RESET;
      s_r.a             <= WORD_RESET;
      s_r.shift_counter <= COUNT_RESET;
      s_r.cnt           <= COUNT_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign q_word        = s_r.q;
  assign x_word        = s_r.x;
  assign a_word        = s_r.a;
  assign shift_counter = s_r.shift_counter;
  assign flags         = s_r.flags;
  assign pulses        = s_r.pulses;
  assign div_check_ff  = s_r.div_chk;
  assign fault_a_stop  = s_r.fault_stop;
  assign busy          = !idle;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_logical_entry: assert property (idle && start_logical |=> s_r.st == ST_L_XFER
    ##1 (s_r.x == $past(s_r.q) && s_r.flags.extended_sequence_flag
         && s_r.flags.logical_busy_flag && s_r.flags.delayed_add_flag)
    ##1 (s_r.a == $past(s_r.x) && !s_r.flags.delayed_add_flag)
    ##1 (s_r.pulses.right_probe && s_r.pulses.left_probe && s_r.x == WORD_RESET))
    else $error("logical entry steps wrong");
  a_first_complement: assert property (s_r.st == ST_L_SETB |=>
    s_r.flags.restore_exchange_flag && s_r.flags.b_probe && !s_r.flags.right_probe_flag
    ##1 s_r.x == ~$past(s_r.x))
    else $error("first complement wrong");
  a_quotient_move: assert property (s_r.st == ST_L_SETC |=> s_r.flags.c_probe
    && !s_r.flags.b_probe && !s_r.flags.restore_exchange_flag
    ##1 (s_r.x == $past(s_r.q) && s_r.q == WORD_RESET))
    else $error("quotient move wrong");
  a_second_complement: assert property (s_r.st == ST_L_SETD |=> s_r.flags.d_probe
    && !s_r.flags.c_probe && !s_r.flags.extended_sequence_flag ##1 s_r.x == ~$past(s_r.x))
    else $error("second complement wrong");
  a_logical_resume: assert property (s_r.st == ST_L_XQ |=> s_r.pulses.resume
    && s_r.q == $past(s_r.x) && s_r.x == WORD_RESET && s_r.flags.e_probe)
    else $error("logical resume wrong");
  a_logical_end: assert property (s_r.st == ST_L_END |=> idle && !s_r.flags.e_probe
    && !s_r.flags.logical_busy_flag)
    else $error("logical end wrong");
  a_full_rotate: assert property ($rose(s_r.st == ST_S_TEST) |->
    s_r.a == $past(s_r.a, 36))
    else $error("full rotation changed the word");
  a_scale_stop: assert property (s_r.st == ST_S_TEST && bits_differ |=> idle
    && s_r.pulses.resume && s_r.shift_counter == $past(s_r.cnt))
    else $error("scale stop wrong");
  a_scale_shift: assert property (s_r.st == ST_S_TEST && !bits_differ
    && s_r.cnt != SF_LAST |=> s_r.st == ST_S_TEST && s_r.a == rotl1($past(s_r.a)))
    else $error("scale shift wrong");
  a_shift_count: assert property (s_r.st == ST_S_TEST && s_r.cnt == SF_LAST |=>
    idle && s_r.shift_counter == SF_LAST)
    else $error("shift count wrong");
  a_divide_probe: assert property (idle && start_divide && !start_logical && !start_scale
    |=> s_r.st == ST_D_CHECK ##1 (s_r.pulses.div_probe && s_r.div_chk == $past(div_check_cond)))
    else $error("divide probe wrong");
  a_divide_clear: assert property (s_r.st == ST_D_CLEAR && !s_r.fault_stop |=>
    s_r.div_chk == 2'h0 && !s_r.fault_stop && s_r.pulses.resume)
    else $error("divide clear wrong");
  a_fault_stop: assert property (s_r.st == ST_D_CHECK && (|div_check_cond) |=>
    fault_a_stop)
    else $error("fault stop missing");
  a_step_order: assert property (s_r.st == ST_L_PROBE |=> s_r.st == ST_L_SETB
    ##1 s_r.st == ST_L_COMP1 ##1 s_r.st == ST_L_SETC)
    else $error("step order wrong");

  c_logical_done: cover property (s_r.st == ST_L_END ##1 idle);
  c_scale_early: cover property (s_r.st == ST_S_TEST && bits_differ && s_r.cnt != COUNT_RESET);
  c_scale_full: cover property (s_r.st == ST_S_TEST && s_r.cnt == SF_LAST);
  c_divide_fault: cover property (s_r.st == ST_D_CHECK && (|div_check_cond));

endmodule

// File: asqc_ctc_model.sv
// ****************************************************************
// Command timing controller model
// ****************************************************************
module asqc_cmd_timing_model (
  input  wire logic                   core_clk,
  input  wire asqc_pkg::asqc_pulses_t pulses,
  input  wire logic [1:0]             div_check_ff,
  output logic                        start_logical,
  output logic                        start_scale,
  output logic                        start_divide
);
  timeunit 1ns;
  timeprecision 1ps;
  import asqc_pkg::*;

  initial begin
    start_logical = 1'b0;
    start_scale   = 1'b0;
    start_divide  = 1'b0;
  end

  // Issues one command after a gap, then counts probe pulses until resume.
  // The bound stops a lost resume from hanging the caller.
  task automatic issue(input int kind, input int gap, output int cyc, output int nr,
                       output int nl, output int nd, output logic [1:0] ff_seen,
                       output bit ok);
    nr = 0;
    nl = 0;
    nd = 0;
    ok = 1'b0;
    ff_seen = 2'b00;
    repeat (gap) @(negedge core_clk);
    start_logical = (kind == 0);
    start_scale   = (kind == 1);
    start_divide  = (kind == 2);
    @(negedge core_clk);
    start_logical = 1'b0;
    start_scale   = 1'b0;
    start_divide  = 1'b0;
    for (cyc = 1; cyc < 200; cyc++) begin
      if (pulses.right_probe === 1'b1) nr++;
      if (pulses.left_probe === 1'b1) nl++;
      if (pulses.div_probe === 1'b1) begin
        if (nd == 0) ff_seen = div_check_ff;
        nd++;
      end
      if (pulses.resume === 1'b1) begin
        ok = 1'b1;
        break;
      end
      @(negedge core_clk);
    end
  endtask
endmodule

// File: tb_asqc_arith_seq_ctrl.sv
`define CHK(name, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
    end \
  end

module tb_asqc_arith_seq_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import asqc_pkg::*;

  logic                   core_clk;
  logic                   reset_n;
  logic                   start_logical;
  logic                   start_scale;
  logic                   start_divide;
  logic [1:0]             div_check_cond;
  logic                   fault_clear;
  logic                   load_q;
  logic                   load_a;
  logic [WORD_W-1:0]      load_data;
  logic [WORD_W-1:0]      q_word;
  logic [WORD_W-1:0]      x_word;
  logic [WORD_W-1:0]      a_word;
  logic [SHIFT_CNT_W-1:0] shift_counter;
  asqc_flags_t            flags;
  asqc_pulses_t           pulses;
  logic [1:0]             div_check_ff;
  logic                   fault_a_stop;
  logic                   busy;
  int                     fails;
  int                     checks_done;
  int                     cyc, nr, nl, nd, k;
  logic [1:0]             ff_seen;
  bit                     ok;
  logic [WORD_W-1:0]      qv [2] = '{36'h1_2345_6789, 36'h0_0000_0000};
  logic [WORD_W-1:0]      av [6] = '{36'h4_0000_0000, 36'h8_0000_0000, 36'hc_0000_0000,
                                     36'h1_0000_0000, 36'hf_ffff_ffff, 36'h0_0000_0001};

  asqc_arith_seq_ctrl u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .start_logical(start_logical),
    .start_scale(start_scale), .start_divide(start_divide),
    .div_check_cond(div_check_cond), .fault_clear(fault_clear), .load_q(load_q),
    .load_a(load_a), .load_data(load_data), .q_word(q_word), .x_word(x_word),
    .a_word(a_word), .shift_counter(shift_counter), .flags(flags), .pulses(pulses),
    .div_check_ff(div_check_ff), .fault_a_stop(fault_a_stop), .busy(busy)
  );

  asqc_cmd_timing_model u_cmd_timing (
    .core_clk(core_clk), .pulses(pulses), .div_check_ff(div_check_ff),
    .start_logical(start_logical), .start_scale(start_scale), .start_divide(start_divide)
  );

  // ****************************************************************
  // Clock, closing and watchdog
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; this is four thousand.
  initial begin
    #100000;
    fails++;
    $display("Watchdog expired before the tests ended");
    end_sim();
  end

  // Expected shift count: first k whose tested pair differs, capped at 34.
  function automatic int exp_k(input logic [WORD_W-1:0] a);
    for (int i = 0; i < 34; i++) if (a[34-i] != a[35-i]) return i;
    return 34;
  endfunction

  task automatic load_word(input logic to_q, input logic [WORD_W-1:0] w);
    load_q    = to_q;
    load_a    = ~to_q;
    load_data = w;
    @(negedge core_clk);
    load_q = 1'b0;
    load_a = 1'b0;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    div_check_cond = 2'b00;
    fault_clear = 1'b0;
    load_q = 1'b0;
    load_a = 1'b0;
    load_data = '0;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    // Logical sequence; a load attempted while busy must be ignored.
    foreach (qv[i]) begin
      load_word(1'b1, qv[i]);
      load_word(1'b0, 36'h5_a5a5_a5a5);
      fork
        u_cmd_timing.issue(0, i * 3, cyc, nr, nl, nd, ff_seen, ok);
        begin
          repeat (i * 3 + 4) @(negedge core_clk);
          load_word(1'b1, 36'hf_0f0f_0f0f);
        end
      join
      `CHK("logical_resume", 1'b1, ok)
      `CHK("logical_steps", 12, cyc)
      `CHK("right_probe_count", 1, nr)
      `CHK("left_probe_count", 1, nl)
      `CHK("e_probe_at_resume", 1'b1, flags.e_probe)
      `CHK("busy_flag_at_resume", 1'b1, flags.logical_busy_flag)
      `CHK("extended_sequence_flag_at_resume", 1'b0, flags.extended_sequence_flag)
      `CHK("d_probe_at_resume", 1'b0, flags.d_probe)
      @(negedge core_clk);
      `CHK("flags_end", 10'h000, flags)
      `CHK("q_end", ~qv[i], q_word)
      `CHK("x_end", 36'h0_0000_0000, x_word)
      `CHK("a_end", qv[i], a_word)
      `CHK("idle_end", 1'b0, busy)
    end
    // Scale factoring, including the all-bits-tested limit.
    foreach (av[i]) begin
      load_word(1'b0, av[i]);
      k = exp_k(av[i]);
      u_cmd_timing.issue(1, 0, cyc, nr, nl, nd, ff_seen, ok);
      `CHK("scale_resume", 1'b1, ok)
      `CHK("scale_steps", ROT_PLACES + 2 + k, cyc)
      @(negedge core_clk);
      `CHK("shift_count", 6'(k), shift_counter)
      `CHK("scaled_word", (av[i] << k) | (av[i] >> (36 - k)), a_word)
    end
    // Divide checks, every condition pair, issued back to back.
    for (int c = 0; c < 4; c++) begin
      div_check_cond = 2'(c);
      u_cmd_timing.issue(2, 0, cyc, nr, nl, nd, ff_seen, ok);
      `CHK("divide_resume", 1'b1, ok)
      `CHK("divide_steps", 3, cyc)
      `CHK("check_ff_probe", 2'(c), ff_seen)
      `CHK("div_probe_count", 2, nd)
      `CHK("check_ff_cleared", 2'b00, div_check_ff)
      `CHK("fault_stop", (c != 0), fault_a_stop)
    end
    @(negedge core_clk);
    `CHK("fault_stop_held", 1'b1, fault_a_stop)
    fault_clear = 1'b1;
    @(negedge core_clk);
    fault_clear = 1'b0;
    @(negedge core_clk);
    `CHK("fault_stop_clear", 1'b0, fault_a_stop)
    end_sim();
  end
endmodule
